//--- hw/pcs_params.svh
// Purpose: Offsets, field positions and reset values of the clock select
//          and clock status block.
// Assumes: Included by every design file that needs a number.
// Notes:   Definitions only.
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PCS_OFF_OSC_CTRL   8'h00
`define PCS_OFF_PLL_CFG    8'h04
`define PCS_OFF_PCK0_CFG   8'h08
`define PCS_OFF_PCK1_CFG   8'h0c
`define PCS_OFF_PCK2_CFG   8'h10
`define PCS_OFF_IRQ_EN     8'h14
`define PCS_OFF_IRQ_DIS    8'h18
`define PCS_OFF_STATUS     8'h1c
`define PCS_OFF_IRQ_MASK   8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define PCS_OSC_EN_BIT     0
`define PCS_OSC_BYP_BIT    1
`define PCS_OSC_CNT_LSB    8
`define PCS_OSC_CNT_W      8
`define PCS_OSC_MUL        3
`define PCS_PLL_CNT_LSB    8
`define PCS_PLL_CNT_W      6
`define PCS_PLL_MUL_LSB    16
`define PCS_PLL_MUL_W      11
`define PCS_CSS_LSB        0
`define PCS_PSC_LSB        2
`define PCS_ST_OSC_BIT     0
`define PCS_ST_LOCK_BIT    2
`define PCS_ST_MCK_BIT     3
`define PCS_ST_PCK_LSB     8
`define PCS_NUM_PCK        3

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define PCS_FLAG_BITS      32'h0000070d
`define PCS_PSC_RSVD       3'h7
`define PCS_OSC_CTRL_RST   32'h00000000
`define PCS_PLL_CFG_RST    32'h00003f00
`define PCS_PCK_CFG_RST    5'h00
`define PCS_IRQ_EN_RST     32'h00000000
`define PCS_PCK_SETTLE     2'h2

`endif

//--- hw/pcs_pkg.sv
// Purpose: Types shared by the clock select and clock status block.
// Assumes: Constants live in pcs_params.svh.
// Notes:   Types only.
package pcs_pkg;

   // Source select of a programmable clock
   typedef enum logic [1:0] {
      PCS_SRC_SLOW = 2'h0,
      PCS_SRC_MAIN = 2'h1,
      PCS_SRC_RSVD = 2'h2,
      PCS_SRC_PLL = 2'h3
   } pcs_src_t;

   // Prescale code of a programmable clock
   typedef logic [2:0] pcs_psc_t;

   // One register word
   typedef logic [31:0] pcs_word_t;

endpackage

//--- hw/pcs_settle.sv
// Purpose: Counts slow clock ticks until a clock source is settled.
// Assumes: tick is a one-cycle pulse per slow clock rising edge.
// Notes:   A restart pulse drops done and counts again from zero, unless force_done is high.
`timescale 1ns/1ns
module pcs_settle #(
   parameter int CNT_W = 11
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Control
   input wire logic run,
   input wire logic force_done,
   input wire logic restart,
   input wire logic tick,
   input wire logic [CNT_W-1:0] target,
   // Result
   output logic done_q
);
   import pcs_pkg::*;

   logic [CNT_W-1:0] cnt_q;

   // Settle counter; a stopped source drops its flag at once unless force_done is high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else if (ce) begin
         if (!run && !force_done) begin
            cnt_q <= '0;
            done_q <= 1'b0;
         end else if (force_done) begin
            done_q <= 1'b1;
         end else if (restart) begin
            cnt_q <= '0;
            done_q <= 1'b0;
         end else if (!done_q && tick) begin
            if (cnt_q >= target) begin
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

endmodule

//--- hw/pcs_prog_clk.sv
// Purpose: One programmable clock output with source select and prescaler.
// Assumes: Source levels are already synchronised to core_clk.
// Notes:   Output rate is bounded by the sampling at core_clk.
`timescale 1ns/1ns
`include "pcs_params.svh"
module pcs_prog_clk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Synchronised sources, bit 0 slow, 1 main, 2 pll
   input wire logic [2:0] src_lvl,
   input wire logic [2:0] src_rise,
   // Configuration
   input wire pcs_pkg::pcs_src_t css,
   input wire pcs_pkg::pcs_psc_t psc,
   input wire logic cfg_wr,
   // Output
   output logic clk_out_q,
   output logic ready_q
);
   import pcs_pkg::*;

   logic sel_lvl;
   logic sel_rise;
   logic valid;
   logic [5:0] half;
   logic [5:0] cnt_q;
   logic [1:0] seen_q;

   always_comb begin
      case (css)
         PCS_SRC_SLOW: begin
            sel_lvl = src_lvl[0];
            sel_rise = src_rise[0];
         end
         PCS_SRC_MAIN: begin
            sel_lvl = src_lvl[1];
            sel_rise = src_rise[1];
         end
         PCS_SRC_PLL: begin
            sel_lvl = src_lvl[2];
            sel_rise = src_rise[2];
         end
         default: begin
            sel_lvl = 1'b0;
            sel_rise = 1'b0;
         end
      endcase
   end

   // Reserved codes keep the output parked low and never ready
   assign valid = (css != PCS_SRC_RSVD) && (psc != `PCS_PSC_RSVD);
   // toggle every half period of source rises
   assign half = (psc == 3'h0) ? 6'h01 : 6'((7'h01 << psc) >> 1);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         clk_out_q <= 1'b0;
      end else if (ce) begin
         if (cfg_wr || !valid) begin
            cnt_q <= '0;
            clk_out_q <= 1'b0;
         end else if (psc == 3'h0) begin
            clk_out_q <= sel_lvl;
         end else if (sel_rise) begin
            if (cnt_q + 6'h01 >= half) begin
               cnt_q <= '0;
               clk_out_q <= ~clk_out_q;
            end else begin
               cnt_q <= cnt_q + 6'h01;
            end
         end
      end
   end

   // ready after two source rises since the last change
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= '0;
         ready_q <= 1'b0;
      end else if (ce) begin
         if (cfg_wr || !valid) begin
            seen_q <= '0;
            ready_q <= 1'b0;
         end else if (sel_rise && !ready_q) begin
            seen_q <= seen_q + 2'h1;
            ready_q <= (seen_q + 2'h1) >= `PCS_PCK_SETTLE;
         end
      end
   end

endmodule

//--- hw/pcs_top.sv
// Purpose: Programmable clock select and clock status block on AHB-Lite.
// Assumes: Slow, main and pll clocks arrive as pins far slower than core_clk.
// Notes:   Zero wait state slave; every answer is OKAY.
//
// Functional notes
// - CSS 00 slow, 01 main, 11 pll.
// - Prescale codes divide by one to 64.
// - Enable, disable, status, mask share bit layout.
// - Enable write ones set source enables.
// - Disable write ones clear source enables.
// - Status bit 0 shows oscillator stable.
// - Status bit 2 shows pll locked.
// - Status bit 3 shows master clock ready.
// - Status bits 8-10 show programmable clocks ready.
// - Mask reads zero enabled, one disabled.
// - Oscillator stable on tick count times eight plus one.
// - Lock on tick pll settle count plus one.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "pcs_params.svh"
module pcs_top (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire pcs_pkg::pcs_word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output pcs_pkg::pcs_word_t hrdata,
   output logic hresp,
   // Clock source pins
   input wire logic slow_clk_pin,
   input wire logic main_clk_pin,
   input wire logic pll_clk_pin,
   input wire logic mck_ready_pin,
   // Outputs
   output logic [2:0] prog_clk_out,
   output logic irq
);
   import pcs_pkg::*;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_ff1_q;
   logic rst_n_q;

   // Two flops so the release is clean with respect to core_clk
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_ff1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_ff1_q <= 1'b1;
         rst_n_q <= rst_ff1_q;
      end
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [3:0] pin_ff1_q;
   logic [3:0] pin_ff2_q;
   logic [2:0] src_old_q;
   logic [2:0] src_rise;

   // First stage is read only by the second stage
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_ff1_q <= '0;
         pin_ff2_q <= '0;
         src_old_q <= '0;
      end else if (ce) begin
         pin_ff1_q <= {mck_ready_pin, pll_clk_pin, main_clk_pin,
                       slow_clk_pin};
         pin_ff2_q <= pin_ff1_q;
         src_old_q <= pin_ff2_q[2:0];
      end
   end

   // Rising edges of the three sources, one cycle pulses
   assign src_rise = pin_ff2_q[2:0] & ~src_old_q;

   // ****************************************************************
   // AHB-Lite address phase capture
   // ****************************************************************
   logic take;
   logic wr_q;
   logic [7:0] waddr_q;
   logic [7:0] aaddr;
   logic wr_now;

   assign take = hsel && htrans[1] && hready;
   assign aaddr = haddr[7:0];
   // Write lands at the edge that ends its data phase
   assign wr_now = wr_q && hready;

   // Hold the write address into the data phase; hsize is word only
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_q <= 1'b0;
         waddr_q <= '0;
      end else if (ce) begin
         if (hready) begin
            wr_q <= take && hwrite && (haddr[31:8] == 24'h000000);
            waddr_q <= aaddr;
         end
      end
   end

   function automatic logic hit(input logic [7:0] off);
      hit = wr_now && (waddr_q == off);
   endfunction

   // ****************************************************************
   // Control registers
   // ****************************************************************
   pcs_word_t osc_ctrl_q;
   pcs_word_t pll_cfg_q;
   logic [4:0] pck_cfg_q [`PCS_NUM_PCK];
   pcs_word_t irq_en_q;
   logic osc_wr;
   logic pll_wr;
   logic [2:0] pck_wr;

   // Write strobes; a process so that what hit reads is followed too
   always_comb begin
      osc_wr = hit(`PCS_OFF_OSC_CTRL);
      pll_wr = hit(`PCS_OFF_PLL_CFG);
      pck_wr[0] = hit(`PCS_OFF_PCK0_CFG);
      pck_wr[1] = hit(`PCS_OFF_PCK1_CFG);
      pck_wr[2] = hit(`PCS_OFF_PCK2_CFG);
   end

   // Oscillator and pll control words
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         osc_ctrl_q <= `PCS_OSC_CTRL_RST;
         pll_cfg_q <= `PCS_PLL_CFG_RST;
      end else if (ce) begin
         if (osc_wr) begin
            osc_ctrl_q <= hwdata;
         end
         if (pll_wr) begin
            pll_cfg_q <= hwdata;
         end
      end
   end

   // Programmable clock words, five bits each
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         for (int i = 0; i < `PCS_NUM_PCK; i++) begin
            pck_cfg_q[i] <= `PCS_PCK_CFG_RST;
         end
      end else if (ce) begin
         for (int i = 0; i < `PCS_NUM_PCK; i++) begin
            if (pck_wr[i]) begin
               pck_cfg_q[i] <= hwdata[4:0];
            end
         end
      end
   end

   // enable state touched only by enable and disable writes
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq_en_q <= `PCS_IRQ_EN_RST;
      end else if (ce) begin
         if (hit(`PCS_OFF_IRQ_EN)) begin
            irq_en_q <= irq_en_q | (hwdata & `PCS_FLAG_BITS);
         end
         if (hit(`PCS_OFF_IRQ_DIS)) begin
            irq_en_q <= irq_en_q & ~(hwdata & `PCS_FLAG_BITS);
         end
      end
   end

   // ****************************************************************
   // Oscillator and pll settle counters
   // ****************************************************************
   logic osc_stable;
   logic pll_lock;
   logic [10:0] osc_target;
   logic [`PCS_PLL_CNT_W-1:0] pll_target;
   logic pll_on;

   // start-up count in slow clocks times eight
   assign osc_target = 11'({osc_ctrl_q[`PCS_OSC_CNT_LSB +: `PCS_OSC_CNT_W],
                            `PCS_OSC_MUL'h0});
   assign pll_target = pll_cfg_q[`PCS_PLL_CNT_LSB +: `PCS_PLL_CNT_W];
   // A zero multiplier turns the pll off, so it never locks
   assign pll_on = |pll_cfg_q[`PCS_PLL_MUL_LSB +: `PCS_PLL_MUL_W];

   // oscillator stable counter, bypass sets it at once
   pcs_settle #(
      .CNT_W(11)
   ) u_osc (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .ce(ce),
      .run(osc_ctrl_q[`PCS_OSC_EN_BIT]),
      .force_done(osc_ctrl_q[`PCS_OSC_BYP_BIT]),
      .restart(osc_wr),
      .tick(src_rise[0]),
      .target(osc_target),
      .done_q(osc_stable)
   );

   // lock counter restarted by each pll config write
   pcs_settle #(
      .CNT_W(`PCS_PLL_CNT_W)
   ) u_pll (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .ce(ce),
      .run(pll_on),
      .force_done(1'b0),
      .restart(pll_wr),
      .tick(src_rise[0]),
      .target(pll_target),
      .done_q(pll_lock)
   );

   // ****************************************************************
   // Programmable clocks
   // ****************************************************************
   logic [2:0] pck_ready;

   // each output picks its own source and prescale
   for (genvar g = 0; g < `PCS_NUM_PCK; g++) begin : g_pck
      pcs_prog_clk u_pck (
         .core_clk(core_clk),
         .rst_n(rst_n_q),
         .ce(ce),
         .src_lvl(pin_ff2_q[2:0]),
         .src_rise(src_rise),
         .css(pcs_src_t'(pck_cfg_q[g][`PCS_CSS_LSB +: 2])),
         .psc(pcs_psc_t'(pck_cfg_q[g][`PCS_PSC_LSB +: 3])),
         .cfg_wr(pck_wr[g]),
         .clk_out_q(prog_clk_out[g]),
         .ready_q(pck_ready[g])
      );
   end

   // ****************************************************************
   // Status, interrupt and read data
   // ****************************************************************
   pcs_word_t status;
   pcs_word_t rd_word;

   always_comb begin
      status = '0;
      status[`PCS_ST_OSC_BIT] = osc_stable;
      status[`PCS_ST_LOCK_BIT] = pll_lock;
      status[`PCS_ST_MCK_BIT] = pin_ff2_q[3];
      status[`PCS_ST_PCK_LSB +: 3] = pck_ready;
   end

   // Read mux; write-only and unmapped words read zero
   always_comb begin
      case (aaddr)
         `PCS_OFF_OSC_CTRL: rd_word = osc_ctrl_q;
         `PCS_OFF_PLL_CFG: rd_word = pll_cfg_q;
         `PCS_OFF_PCK0_CFG: rd_word = {27'h0, pck_cfg_q[0]};
         `PCS_OFF_PCK1_CFG: rd_word = {27'h0, pck_cfg_q[1]};
         `PCS_OFF_PCK2_CFG: rd_word = {27'h0, pck_cfg_q[2]};
         `PCS_OFF_STATUS: rd_word = status;
         // mask reads one for a disabled source
         `PCS_OFF_IRQ_MASK: rd_word = ~irq_en_q & `PCS_FLAG_BITS;
         default: rd_word = '0;
      endcase
      if (haddr[31:8] != 24'h000000) begin
         rd_word = '0;
      end
   end

   // Bus answer flops; the slave never stretches a transfer
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= '0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (take && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(status & irq_en_q);
      end
   end

endmodule

//--- dv/pcs_properties.sv
// Purpose: Bus and interrupt checks on the clock status block.
// Assumes: No bus write lands directly before a read.
// Notes:   Enable state is mirrored from bus writes.
`timescale 1ns/1ns
`include "pcs_params.svh"
module pcs_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Bus
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire pcs_pkg::pcs_word_t hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire pcs_pkg::pcs_word_t hrdata,
   input wire logic hresp,
   // Pins
   input wire logic mck_ready_pin,
   input wire logic irq
);
   import pcs_pkg::*;
   logic rd;
   logic wr_q;
   logic [7:0] wa_q;
   logic [5:0] mk_q;
   pcs_word_t en_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ****************************************************************
   // Mirror of the enable state
   // ****************************************************************
   assign rd = hsel & htrans[1] & hready & ce & !hwrite;
   // Writes land at the end of the data phase, as in the design
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         en_q <= 32'h0;
         mk_q <= 6'h00;
      end else begin
         wr_q <= hsel & htrans[1] & hready & ce & hwrite;
         wa_q <= haddr[7:0];
         mk_q <= {mk_q[4:0], mck_ready_pin};
         if (wr_q && wa_q == `PCS_OFF_IRQ_EN) en_q <= en_q | hwdata;
         if (wr_q && wa_q == `PCS_OFF_IRQ_DIS) en_q <= en_q & ~hwdata;
      end
   end
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("wait state seen");
   a_irq_needs_en: assert property
      ((en_q & `PCS_FLAG_BITS) == 0 |=> !irq) else $error("irq unmasked");
   a_irq_follows: assert property
      (en_q[3] && (&mk_q) |=> irq) else $error("irq missing");
   a_mask_readback: assert property
      (rd && haddr == {24'h0, `PCS_OFF_IRQ_MASK} |-> ##2
       hrdata == (`PCS_FLAG_BITS & ~$past(en_q))) else $error("mask read");
   a_endis_zero: assert property
      (rd && (haddr == {24'h0, `PCS_OFF_IRQ_EN} ||
       haddr == {24'h0, `PCS_OFF_IRQ_DIS}) |-> ##2 hrdata == 0)
      else $error("write-only read");
   a_unmapped_zero: assert property
      (rd && haddr[31:8] != 0 |-> ##2 hrdata == 0) else $error("unmapped");
   a_status_layout: assert property
      (rd && haddr == {24'h0, `PCS_OFF_STATUS} |-> ##2
       (hrdata & ~`PCS_FLAG_BITS) == 0) else $error("status layout");
   a_mck_flag: assert property
      (rd && haddr == {24'h0, `PCS_OFF_STATUS} && (&mk_q || !mk_q) |-> ##2
       hrdata[`PCS_ST_MCK_BIT] == $past(mck_ready_pin, 4))
      else $error("master ready flag");
endmodule
bind pcs_top pcs_checker i_pcs_checker (.core_clk(core_clk), .rstn(rstn),
   .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .mck_ready_pin(mck_ready_pin),
   .irq(irq));

//--- dv/testbench.sv
// Purpose: Self-checking bench for the clock select and status block.
// Assumes: Zero wait AHB-Lite slave; source pins far slower than core_clk.
// Notes:   Reads queue their expectation; a monitor compares them.
`timescale 1ns/1ns
`include "pcs_params.svh"
module testbench;
   import pcs_pkg::*;
   logic core_clk = 0;
   logic rstn = 0;
   logic hsel = 0;
   logic [31:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic hwrite = 0;
   logic rd_q = 0;
   pcs_word_t hwdata = 0;
   logic hready;
   pcs_word_t hrdata;
   logic hresp;
   logic [3:0] pin = 0;
   logic [2:0] prog_clk_out;
   logic [2:0] po = 0;
   logic irq;
   int pc = 0;
   int cyc = 0;
   int srise[3] = '{0, 0, 0};
   int orise[3] = '{0, 0, 0};
   int err_count = 0;
   int check_count = 0;
   pcs_word_t exp_q[$];
   pcs_word_t msk_q[$];
   pcs_word_t r;
   pcs_word_t r2;
   pcs_top i_pcs_top (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .slow_clk_pin(pin[0]), .main_clk_pin(pin[1]), .pll_clk_pin(pin[2]),
      .mck_ready_pin(pin[3]), .prog_clk_out(prog_clk_out), .irq(irq));
   // ****************************************************************
   // Clock, source pins, edge counters
   // ****************************************************************
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   // Sources stay slow so the two-flop samplers see every level
   always @(posedge core_clk) begin
      pc <= pc + 1;
      po <= prog_clk_out;
      if (pc % 16 == 15) pin[0] <= ~pin[0];
      if (pc % 16 == 15 && !pin[0]) srise[0] <= srise[0] + 1;
      if (pc % 2 == 1) pin[1] <= ~pin[1];
      if (pc % 2 == 1 && !pin[1]) srise[1] <= srise[1] + 1;
      if (pc % 3 == 2) pin[2] <= ~pin[2];
      if (pc % 3 == 2 && !pin[2]) srise[2] <= srise[2] + 1;
      for (int k = 0; k < 3; k++) begin
         if (prog_clk_out[k] && !po[k]) orise[k] <= orise[k] + 1;
      end
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         complete_run();
      end
   end
   // Read results leave the data phase at the edge where hready is high
   always @(posedge core_clk) begin
      if (rd_q && hready === 1'b1) cmp(hrdata, exp_q.pop_front(),
         msk_q.pop_front());
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic cmp(input pcs_word_t g, input pcs_word_t e,
                      input pcs_word_t m);
      check_count++;
      if ((g & m) !== (e & m)) begin
         err_count++;
         $display("MISMATCH %0t got %h want %h", $time, g & m, e & m);
      end
   endtask
   task automatic cmp_cnt(input int g, input int e);
      check_count++;
      if (g < e - 1 || g > e + 1) begin
         err_count++;
         $display("MISMATCH %0t edges %0d want %0d", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a,
                      input pcs_word_t d, input pcs_word_t m);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) exp_q.push_back(d);
      if (!w) msk_q.push_back(m);
      rd_q <= !w;
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      rd_q <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input pcs_word_t d);
      bus(1'b1, {24'h0, a}, d, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input pcs_word_t e,
                     input pcs_word_t m);
      bus(1'b0, {24'h0, a}, e, m);
   endtask
   task automatic pck(input int k, input pcs_src_t s, input pcs_psc_t p);
      int i;
      int sb;
      int ob;
      logic ok;
      i = (s == PCS_SRC_PLL) ? 2 : int'(s);
      ok = (s != PCS_SRC_RSVD) && (p != `PCS_PSC_RSVD);
      wr(`PCS_OFF_PCK0_CFG + 8'(4 * k), {27'h0, p, s});
      repeat (60) @(posedge core_clk);
      sb = srise[i];
      ob = orise[k];
      repeat (512) @(posedge core_clk);
      cmp_cnt(orise[k] - ob, ok ? (srise[i] - sb) >> p : 0);
      rd(`PCS_OFF_STATUS, ok ? 32'h100 << k : 0, 32'h100 << k);
   endtask
   task automatic complete_run();
      $display("mismatches %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'hf4c6));
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(`PCS_OFF_IRQ_MASK, `PCS_FLAG_BITS, '1);
      rd(`PCS_OFF_IRQ_EN, 0, '1);
      bus(1'b1, 32'h100, $urandom, 0);
      bus(1'b0, 32'h100, 0, '1);
      r = $urandom;
      wr(`PCS_OFF_IRQ_EN, r);
      rd(`PCS_OFF_IRQ_MASK, `PCS_FLAG_BITS & ~r, '1);
      r2 = $urandom;
      wr(`PCS_OFF_IRQ_DIS, r2);
      wr(`PCS_OFF_IRQ_MASK, 32'h0);
      wr(`PCS_OFF_STATUS, '1);
      rd(`PCS_OFF_IRQ_MASK, `PCS_FLAG_BITS & (~r | r2), '1);
      wr(`PCS_OFF_IRQ_DIS, '1);
      wr(`PCS_OFF_OSC_CTRL, 32'h2);
      repeat (6) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h1, 32'h1);
      wr(`PCS_OFF_OSC_CTRL, 32'h0);
      repeat (6) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h0, 32'h1);
      wr(`PCS_OFF_OSC_CTRL, 32'h101);
      repeat (100) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h0, 32'h1);
      // Nine slow rises of 32 cycles each, plus one slow phase of slack
      repeat (200) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h1, 32'h1);
      wr(`PCS_OFF_PLL_CFG, 32'h00010400);
      repeat (30) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h0, 32'h4);
      // Five slow rises of 32 cycles each must have passed by now
      repeat (150) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h4, 32'h4);
      pin[3] <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h8, 32'h8);
      wr(`PCS_OFF_IRQ_EN, 32'h8);
      repeat (4) @(posedge core_clk);
      cmp({31'h0, irq}, 32'h1, 32'h1);
      wr(`PCS_OFF_IRQ_DIS, 32'h8);
      repeat (4) @(posedge core_clk);
      cmp({31'h0, irq}, 32'h0, 32'h1);
      pin[3] <= 1'b0;
      repeat (8) @(posedge core_clk);
      rd(`PCS_OFF_STATUS, 32'h0, 32'h8);
      for (int p = 0; p < 8; p++) pck(0, PCS_SRC_MAIN, 3'(p));
      pck(1, PCS_SRC_SLOW, 3'($urandom_range(6)));
      pck(2, PCS_SRC_PLL, 3'($urandom_range(6)));
      pck(0, PCS_SRC_RSVD, 3'h1);
      complete_run();
   end
endmodule
